// ===== clock_gear_pkg.sv
// constants, encodings and state carrier for the clock mode and gear block
package clock_gear_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses (apb, one aligned word each)
    localparam logic [11:0] ADDR_CLK_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STANDBY = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;

    // clock control register fields
    localparam int SPEED_LSB = 0;
    localparam int SRC_SEL_BIT = 2;
    localparam int WAIT_LSB = 3;
    localparam int MONITOR_BIT = 7;

    // standby register fields
    localparam int STBY_TYPE_LSB = 0;
    localparam int SW_RESET_BIT = 4;
    localparam logic [1:0] STBY_SLEEP = 2'h1;
    localparam logic [1:0] STBY_STOP = 2'h2;
    localparam logic [1:0] STBY_WATCH = 2'h3;

    // status register fields
    localparam int STAT_MAIN_OSC_BIT = 0;
    localparam int STAT_SUB_OSC_BIT = 1;
    localparam int STAT_CPU_HOLD_BIT = 2;
    localparam int STAT_MODE_LSB = 4;

    // reset values
    localparam logic [1:0] SPEED_RST = 2'h0;
    localparam logic SRC_SEL_RST = 1'b1;

    // gear divisors in main oscillator periods, one per speed setting
    localparam logic [6:0] DIV_SPEED_0 = 7'h40;
    localparam logic [6:0] DIV_SPEED_1 = 7'h10;
    localparam logic [6:0] DIV_SPEED_2 = 7'h08;
    localparam logic [6:0] DIV_SPEED_3 = 7'h04;

    // timebase counter and watch prescaler widths
    localparam int TB_W = 19;
    localparam int WP_W = 15;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        main_run,
        main_sleep,
        main_stop,
        main_wait,
        sub_run,
        sub_to_main_wait,
        sub_sleep,
        sub_stop,
        sub_wait,
        watch_mode
    } mode_t;

    typedef struct packed {
        mode_t mode;
        logic [1:0] speed;
        logic src_sel;
        logic [1:0] wait_sel;
        logic [6:0] div_cnt;
        logic sub_ph;
        logic [TB_W-1:0] tb;
        logic [WP_W-1:0] wp;
        logic [2:0] sub_sync;
        logic [1:0] ext_sync;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cpu_en;
        logic per_en;
        logic tb_en;
        logic wp_en;
        logic main_osc_en;
        logic sub_osc_en;
        logic cpu_hold;
    } state_t;

endpackage

// ===== clock_gear.sv
// clock mode selection, gear divider and oscillator stabilization waits
//
// Function
// R01: two-bit speed field picks one of four main clock divisions, 00 to 11.
// R02: timebase counter and watch prescaler ignore the speed field.
// R03: main run keeps both oscillators; prescaler on sub, rest on main.
// R04: standby in main mode enters main sleep or main stop by type.
// R05: any reset ends standby and resumes in run mode.
// R06: writing source select 0 in main mode switches to sub-oscillator.
// R07: readable monitor bit shows which oscillator supplies the system.
// R08: software waits past sub stabilization after power-up before sub mode.
// R09: sub run stops the main oscillator; timebase counter halts.
// R10: standby in sub mode enters sub sleep, sub stop or watch by type.
// R11: writing 1 in sub mode restarts main; switch after main wait expires.
// R12: wait-select bits pick main wait for stop wake and sub-to-main switch.
// R13: software leaves wait-select alone until monitor bit reads 1.
// R14: main wait clears timebase counter and runs until selected bit sets.
// R15: wait-select reset value is a build-time option.
// R16: power-on variant waits on power-on, sub-mode resets, stop external reset.
// R17: no power-on variant waits only on soft and watchdog resets in sub mode.
// R18: external wake from sub stop waits two to fifteenth sub periods.
// R19: sub wait runs from cleared watch prescaler to its overflow.
// R20: cpu clock withheld until the applicable stabilization wait ends.
// R21: monitor reads 0 on sub incl. main wait, 1 in main mode; read-only.
// R22: speed 00,01,10,11 give 64,16,8,4 main periods per cpu clock.
// R23: sub clock keeps running during main wait; changeover is glitch-free.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ns
module clock_gear #(
    parameter bit HAS_POR = 1'b1,
    parameter logic [1:0] WAIT_SEL_RST = 2'h3,
    parameter int WAIT_BIT_0 = 4,
    parameter int WAIT_BIT_1 = 12,
    parameter int WAIT_BIT_2 = 16,
    parameter int WAIT_BIT_3 = 18
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic sub_osc_in,
    input wire logic ext_irq_in,
    input wire logic periph_irq_in,
    input wire logic por_req_in,
    input wire logic ext_reset_in,
    input wire logic wdt_reset_in,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out,
    output logic timebase_en_out,
    output logic prescaler_en_out,
    output logic main_osc_en_out,
    output logic sub_osc_en_out,
    output logic cpu_hold_out
);

    ////////////////////////////////////////////////////////////////////////
    localparam clock_gear_pkg::state_t RST_STATE = '{
        mode: (HAS_POR ? clock_gear_pkg::main_wait : clock_gear_pkg::main_run),
        speed: clock_gear_pkg::SPEED_RST,
        src_sel: clock_gear_pkg::SRC_SEL_RST,
        wait_sel: WAIT_SEL_RST,
        div_cnt: 7'h00,
        sub_ph: 1'b0,
        tb: '0,
        wp: '0,
        sub_sync: 3'h0,
        ext_sync: 2'h0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        cpu_en: 1'b0,
        per_en: 1'b0,
        tb_en: 1'b0,
        wp_en: 1'b0,
        main_osc_en: 1'b1,
        sub_osc_en: 1'b1,
        cpu_hold: 1'b1
    };

    clock_gear_pkg::state_t s_q;
    clock_gear_pkg::state_t s_d;

    function automatic logic [6:0] gear_div(input logic [1:0] sel);
        logic [6:0] d;
        d = clock_gear_pkg::DIV_SPEED_0;
        unique case (sel)
            2'h0: d = clock_gear_pkg::DIV_SPEED_0;
            2'h1: d = clock_gear_pkg::DIV_SPEED_1;
            2'h2: d = clock_gear_pkg::DIV_SPEED_2;
            2'h3: d = clock_gear_pkg::DIV_SPEED_3;
        endcase
        return d;
    endfunction

    // selected timebase bit, counted from a cleared counter
    function automatic logic wait_done(input logic [1:0] sel,
                                       input logic [clock_gear_pkg::TB_W-1:0] tb);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'h0: r = tb[WAIT_BIT_0];
            2'h1: r = tb[WAIT_BIT_1];
            2'h2: r = tb[WAIT_BIT_2];
            2'h3: r = tb[WAIT_BIT_3];
        endcase
        return r;
    endfunction

    function automatic logic in_sub(input clock_gear_pkg::mode_t m);
        return m inside {clock_gear_pkg::sub_run,
                         clock_gear_pkg::sub_to_main_wait,
                         clock_gear_pkg::sub_sleep,
                         clock_gear_pkg::sub_stop,
                         clock_gear_pkg::sub_wait,
                         clock_gear_pkg::watch_mode};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic sub_tick;
    logic main_tick;
    logic sub_cpu_tick;
    logic ext_irq;
    logic any_irq;
    logic wr_ctrl;
    logic wr_stby;
    logic sw_reset;
    logic any_reset;
    logic reset_wait;
    logic main_on;
    logic sub_on;
    logic [1:0] stby_type;

    always_comb begin
        s_d = s_q;

        // pin synchronisers; only the settled stages feed logic
        s_d.sub_sync = {s_q.sub_sync[1:0], sub_osc_in};
        s_d.ext_sync = {s_q.ext_sync[0], ext_irq_in};
        sub_tick = s_q.sub_sync[1] & ~s_q.sub_sync[2] & s_q.sub_osc_en;
        ext_irq = s_q.ext_sync[1];
        any_irq = ext_irq | periph_irq_in;

        main_on = s_q.mode inside {clock_gear_pkg::main_run, clock_gear_pkg::main_sleep,
                                   clock_gear_pkg::main_wait,
                                   clock_gear_pkg::sub_to_main_wait}; // R03 R09
        sub_on = (s_q.mode != clock_gear_pkg::sub_stop);

        // gear divider, restarts when the main clock is off
        main_tick = 1'b0;
        if (main_on) begin
            if (s_q.div_cnt >= gear_div(s_q.speed) - 7'h01) begin // R01 R22
                main_tick = 1'b1;
                s_d.div_cnt = 7'h00;
            end else begin
                s_d.div_cnt = s_q.div_cnt + 7'h01;
            end
        end else begin
            s_d.div_cnt = 7'h00;
        end

        // sub-clock cpu rate is every second sub tick
        sub_cpu_tick = 1'b0;
        if (sub_tick) begin
            s_d.sub_ph = ~s_q.sub_ph;
            sub_cpu_tick = s_q.sub_ph;
        end

        // free counters run on their own clocks, never the gear
        if (main_on) begin
            s_d.tb = s_q.tb + 1'b1; // R02
        end
        if (sub_tick) begin
            s_d.wp = s_q.wp + 1'b1; // R02 R03
        end

        ////////////////////////////////////////////////////////////////////
        // apb slave: pready rises one cycle after setup, zero-wait access
        wr_ctrl = 1'b0;
        wr_stby = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel_in && !penable_in) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            unique case (paddr_in)
                clock_gear_pkg::ADDR_CLK_CTRL: begin
                    s_d.prdata[clock_gear_pkg::MONITOR_BIT] = !in_sub(s_q.mode); // R07 R21
                    s_d.prdata[clock_gear_pkg::WAIT_LSB +: 2] = s_q.wait_sel;
                    s_d.prdata[clock_gear_pkg::SRC_SEL_BIT] = s_q.src_sel;
                    s_d.prdata[clock_gear_pkg::SPEED_LSB +: 2] = s_q.speed;
                end
                clock_gear_pkg::ADDR_STANDBY: begin
                end
                clock_gear_pkg::ADDR_STATUS: begin
                    s_d.prdata[clock_gear_pkg::STAT_MAIN_OSC_BIT] = s_q.main_osc_en;
                    s_d.prdata[clock_gear_pkg::STAT_SUB_OSC_BIT] = s_q.sub_osc_en;
                    s_d.prdata[clock_gear_pkg::STAT_CPU_HOLD_BIT] = s_q.cpu_hold;
                    s_d.prdata[clock_gear_pkg::STAT_MODE_LSB +: 4] = s_q.mode;
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end else if (psel_in && penable_in && s_q.pready) begin
            s_d.prdata = 32'h0000_0000;
            wr_ctrl = pwrite_in && (paddr_in == clock_gear_pkg::ADDR_CLK_CTRL);
            wr_stby = pwrite_in && (paddr_in == clock_gear_pkg::ADDR_STANDBY);
        end

        stby_type = pwdata_in[clock_gear_pkg::STBY_TYPE_LSB +: 2];
        // software reset only through the standby register
        sw_reset = wr_stby & pwdata_in[clock_gear_pkg::SW_RESET_BIT];

        // monitor bit is not stored, so writes to it have no effect
        if (wr_ctrl) begin
            s_d.speed = pwdata_in[clock_gear_pkg::SPEED_LSB +: 2]; // R01
            s_d.wait_sel = pwdata_in[clock_gear_pkg::WAIT_LSB +: 2]; // R12
            s_d.src_sel = pwdata_in[clock_gear_pkg::SRC_SEL_BIT];
        end

        ////////////////////////////////////////////////////////////////////
        // mode sequencing
        unique case (s_q.mode)
            clock_gear_pkg::main_run: begin
                if (wr_ctrl && !pwdata_in[clock_gear_pkg::SRC_SEL_BIT]) begin
                    s_d.mode = clock_gear_pkg::sub_run; // R06
                    // first sub tick after the switch gives no pulse, no short clock
                    s_d.sub_ph = 1'b0; // R23
                end else if (wr_stby && stby_type == clock_gear_pkg::STBY_SLEEP) begin
                    s_d.mode = clock_gear_pkg::main_sleep; // R04
                end else if (wr_stby && stby_type == clock_gear_pkg::STBY_STOP) begin
                    s_d.mode = clock_gear_pkg::main_stop; // R04
                end
            end
            // sleep wakes on any interrupt, stop only on the external pin
            clock_gear_pkg::main_sleep: begin
                if (any_irq) begin
                    s_d.mode = clock_gear_pkg::main_run;
                end
            end
            clock_gear_pkg::main_stop: begin
                if (ext_irq) begin
                    s_d.mode = clock_gear_pkg::main_wait; // R12
                    s_d.tb = '0; // R14
                end
            end
            clock_gear_pkg::main_wait: begin
                if (wait_done(s_q.wait_sel, s_q.tb)) begin
                    s_d.mode = clock_gear_pkg::main_run; // R14 R20
                end
            end
            clock_gear_pkg::sub_run: begin
                if (wr_ctrl && pwdata_in[clock_gear_pkg::SRC_SEL_BIT]) begin
                    s_d.mode = clock_gear_pkg::sub_to_main_wait; // R11
                    s_d.tb = '0; // R14
                end else if (wr_stby && stby_type == clock_gear_pkg::STBY_SLEEP) begin
                    s_d.mode = clock_gear_pkg::sub_sleep; // R10
                end else if (wr_stby && stby_type == clock_gear_pkg::STBY_STOP) begin
                    s_d.mode = clock_gear_pkg::sub_stop; // R10
                end else if (wr_stby && stby_type == clock_gear_pkg::STBY_WATCH) begin
                    s_d.mode = clock_gear_pkg::watch_mode; // R10
                end
            end
            clock_gear_pkg::sub_to_main_wait: begin
                // software may back out of the switch before it lands
                if (wr_ctrl && !pwdata_in[clock_gear_pkg::SRC_SEL_BIT]) begin
                    s_d.mode = clock_gear_pkg::sub_run;
                end else if (wait_done(s_q.wait_sel, s_q.tb)) begin
                    s_d.mode = clock_gear_pkg::main_run; // R11 R12 R23
                    // gear restarts, so the first main pulse is a full period away
                    s_d.div_cnt = 7'h00; // R23
                end
            end
            clock_gear_pkg::sub_sleep: begin
                if (any_irq) begin
                    s_d.mode = clock_gear_pkg::sub_run;
                end
            end
            clock_gear_pkg::sub_stop: begin
                if (ext_irq) begin
                    s_d.mode = clock_gear_pkg::sub_wait; // R18
                    s_d.wp = '0; // R19
                end
            end
            // fixed sub wait: prescaler must roll over from all ones
            clock_gear_pkg::sub_wait: begin
                if (sub_tick && (&s_q.wp)) begin
                    s_d.mode = clock_gear_pkg::sub_run; // R18 R19 R20
                end
            end
            clock_gear_pkg::watch_mode: begin
                if (any_irq) begin
                    s_d.mode = clock_gear_pkg::sub_run;
                end
            end
            default: s_d.mode = clock_gear_pkg::main_run;
        endcase

        ////////////////////////////////////////////////////////////////////
        // reset sources: run mode always follows, wait by variant
        any_reset = por_req_in | ext_reset_in | wdt_reset_in | sw_reset; // R05
        if (HAS_POR) begin
            reset_wait = por_req_in
                       | in_sub(s_q.mode)
                       | (ext_reset_in & (s_q.mode == clock_gear_pkg::main_stop)); // R16
        end else begin
            reset_wait = (sw_reset | wdt_reset_in) & in_sub(s_q.mode); // R17
        end
        if (any_reset) begin
            s_d.mode = reset_wait ? clock_gear_pkg::main_wait
                                  : clock_gear_pkg::main_run; // R05
            s_d.speed = clock_gear_pkg::SPEED_RST;
            s_d.src_sel = clock_gear_pkg::SRC_SEL_RST;
            s_d.wait_sel = WAIT_SEL_RST; // R15
            s_d.tb = '0; // R14
        end

        ////////////////////////////////////////////////////////////////////
        // enables: switch only on tick boundaries so no clock is shortened
        s_d.cpu_en = 1'b0;
        s_d.per_en = 1'b0;
        unique case (s_q.mode)
            clock_gear_pkg::main_run: begin
                s_d.cpu_en = main_tick; // R01
                s_d.per_en = main_tick;
            end
            clock_gear_pkg::main_sleep: s_d.per_en = main_tick;
            clock_gear_pkg::sub_run, clock_gear_pkg::sub_to_main_wait: begin
                s_d.cpu_en = sub_cpu_tick; // R09 R23
                s_d.per_en = sub_cpu_tick;
            end
            clock_gear_pkg::sub_sleep: s_d.per_en = sub_cpu_tick;
            default: begin
            end
        endcase
        // hold covers both waits; no cpu pulse can leak out of them
        s_d.cpu_hold = s_q.mode inside {clock_gear_pkg::main_wait,
                                        clock_gear_pkg::sub_wait}; // R20
        // timebase freezes whenever the main oscillator is off
        s_d.tb_en = main_on; // R02 R09
        s_d.wp_en = sub_tick; // R02
        s_d.main_osc_en = main_on; // R03 R09
        s_d.sub_osc_en = sub_on; // R03
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign prdata_out = s_q.prdata;
    assign pready_out = s_q.pready;
    assign pslverr_out = s_q.pslverr;
    assign cpu_clk_en_out = s_q.cpu_en;
    assign periph_clk_en_out = s_q.per_en;
    assign timebase_en_out = s_q.tb_en;
    assign prescaler_en_out = s_q.wp_en;
    assign main_osc_en_out = s_q.main_osc_en;
    assign sub_osc_en_out = s_q.sub_osc_en;
    assign cpu_hold_out = s_q.cpu_hold;

endmodule

// ===== clock_gear_assertions.sv
// port-level checker for the clock mode and gear block
`timescale 1ns/1ns
module clock_gear_assertions (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sub_osc_in,
    input wire logic ext_irq_in,
    input wire logic periph_irq_in,
    input wire logic por_req_in,
    input wire logic ext_reset_in,
    input wire logic wdt_reset_in,
    input wire logic cpu_clk_en_out,
    input wire logic periph_clk_en_out,
    input wire logic timebase_en_out,
    input wire logic prescaler_en_out,
    input wire logic main_osc_en_out,
    input wire logic sub_osc_en_out,
    input wire logic cpu_hold_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    a_ready_one_cycle:
        assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("pready not one cycle after setup");
    a_err_data_zero:
        assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error response without ready or with data");
    a_hold_blocks_cpu:
        assert property (cpu_hold_out |-> !cpu_clk_en_out)
        else $error("cpu clock during stabilization wait");
    a_sub_halts_timebase:
        assert property (!main_osc_en_out [*2] |-> !timebase_en_out)
        else $error("timebase runs with main oscillator off");
    a_timebase_with_sub:
        assert property (timebase_en_out |-> sub_osc_en_out)
        else $error("sub oscillator off while main runs");
    a_tick_single_pulse:
        assert property (prescaler_en_out |=> !prescaler_en_out)
        else $error("prescaler pulse longer than one cycle");
    a_gear_min_gap:
        assert property (cpu_clk_en_out |=> !cpu_clk_en_out [*3])
        else $error("cpu enable faster than divide by four");
    a_periph_min_gap:
        assert property (periph_clk_en_out |=> !periph_clk_en_out [*3])
        else $error("peripheral enable faster than divide by four");
endmodule

bind clock_gear clock_gear_assertions clock_gear_assertions_inst (
    .clock_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .sub_osc_in, .ext_irq_in, .periph_irq_in,
    .por_req_in, .ext_reset_in, .wdt_reset_in, .cpu_clk_en_out, .periph_clk_en_out,
    .timebase_en_out, .prescaler_en_out, .main_osc_en_out, .sub_osc_en_out, .cpu_hold_out
);

// ===== tb.sv
// self-checking bench for the clock mode and gear block
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module tb;
    logic clock_in, rst_b_in, psel_in, penable_in, pwrite_in, sub_osc_in, er;
    logic ext_irq_in, periph_irq_in, por_req_in, ext_reset_in, wdt_reset_in;
    logic [4:0] ev;
    logic [11:0] paddr_in, a;
    logic [31:0] pwdata_in, prdata_out, rd, seed;
    logic pready_out, pslverr_out, cpu_clk_en_out, periph_clk_en_out, timebase_en_out;
    logic prescaler_en_out, main_osc_en_out, sub_osc_en_out, cpu_hold_out;
    int n_errors, checks, cyc, t0, g, wb, np;

    assign {ext_irq_in, periph_irq_in, por_req_in, ext_reset_in, wdt_reset_in} = ev;

    // small wait bits keep the run short: 4, 8, 16, 32 cycles
    clock_gear #(.HAS_POR(1'b1), .WAIT_SEL_RST(2'h0), .WAIT_BIT_0(2), .WAIT_BIT_1(3),
        .WAIT_BIT_2(4), .WAIT_BIT_3(5)) clock_gear_inst (
        .clock_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .sub_osc_in, .ext_irq_in, .periph_irq_in,
        .por_req_in, .ext_reset_in, .wdt_reset_in, .cpu_clk_en_out, .periph_clk_en_out,
        .timebase_en_out, .prescaler_en_out, .main_osc_en_out, .sub_osc_en_out, .cpu_hold_out);

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // free-running sub oscillator, period of four clocks; also the hang guard
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        sub_osc_in <= cyc[1];
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int exp_div(input int s);
        case (s)
            0: return 64;
            1: return 16;
            2: return 8;
            default: return 4;
        endcase
    endfunction

    task conclude();
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // idle cycle first, so no signal is driven twice in one step
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= ad;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task mode_is(input clock_gear_pkg::mode_t m);
        apb(1'b0, clock_gear_pkg::ADDR_STATUS, 32'h0);
        `CHK("mode", m, rd[7:4])
    endtask

    task ctrl_is(input logic [31:0] e);
        apb(1'b0, clock_gear_pkg::ADDR_CLK_CTRL, 32'h0);
        `CHK("ctrl", e, rd)
    endtask

    task pulse(input int i, input int n);
        @(posedge clock_in);
        ev <= 5'h01 << i;
        repeat (n) @(posedge clock_in);
        ev <= 5'h0;
    endtask

    task hold_to(input logic v);
        int k;
        k = 0;
        while (cpu_hold_out !== v && k < 60) begin
            @(negedge clock_in);
            k++;
        end
        `CHK("hold", v, cpu_hold_out)
    endtask

    // cycles between two cpu enable pulses, taken after two settling gaps
    task gap_of(output int gg);
        repeat (2) begin
            gg = 0;
            np = 0;
            do @(negedge clock_in); while (cpu_clk_en_out !== 1'b1);
            do begin
                @(negedge clock_in);
                gg++;
                if (prescaler_en_out === 1'b1) np++;
            end while (cpu_clk_en_out !== 1'b1);
        end
        `CHK("periph", 1'b1, periph_clk_en_out)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_errors = 0;
        checks = 0;
        cyc = 0;
        seed = 32'h9259;
        ev = 5'h0;
        {psel_in, penable_in, pwrite_in} = 3'h0;
        paddr_in = 12'h0;
        pwdata_in = 32'h0;
        rst_b_in = 1'b0;
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        @(negedge clock_in);
        `CHK("hold", 1'b1, cpu_hold_out)
        hold_to(1'b0);
        ctrl_is(32'h84);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, clock_gear_pkg::ADDR_CLK_CTRL, 32'h4 | s);
            gap_of(g);
            `CHK("gap", exp_div(s), g)
            `CHK("prescaler", g / 4, np)
            `CHK("timebase", 1'b1, timebase_en_out)
        end
        a = 12'h00c + 12'(xs() % 32'd60) * 12'h4;
        apb(1'b1, a, xs());
        apb(1'b0, a, 32'h0);
        `CHK("unmapped", 33'h100000000, {er, rd})
        apb(1'b1, clock_gear_pkg::ADDR_STATUS, xs());
        apb(1'b0, clock_gear_pkg::ADDR_STATUS, 32'h0);
        `CHK("status", 32'h3, rd)
        apb(1'b1, clock_gear_pkg::ADDR_CLK_CTRL, 32'h07);
        ctrl_is(32'h87);
        // every wait select, round trip main to sub to main
        for (int w = 0; w < 4; w++) begin
            wb = xs() & 32'h3;
            apb(1'b1, clock_gear_pkg::ADDR_CLK_CTRL, 32'(w << 3) | 32'(wb));
            ctrl_is(32'(w << 3) | 32'(wb));
            mode_is(clock_gear_pkg::sub_run);
            `CHK("main osc", 1'b0, main_osc_en_out)
            `CHK("timebase", 1'b0, timebase_en_out)
            if (w == 0) begin
                gap_of(g);
                `CHK("sub gap", 8, g)
                `CHK("sub prescaler", 2, np)
            end
            apb(1'b1, clock_gear_pkg::ADDR_CLK_CTRL, 32'(w << 3) | 32'h4);
            t0 = cyc;
            wb = 2 + w;
            if (w >= 2) begin
                mode_is(clock_gear_pkg::sub_to_main_wait);
                ctrl_is(32'(w << 3) | 32'h4);
            end
            do apb(1'b0, clock_gear_pkg::ADDR_CLK_CTRL, 32'h0);
            while (rd[7] !== 1'b1 && cyc - t0 < 300);
            g = cyc - t0;
            `CHK("main wait", 1'b1, g >= (1 << wb) && g < (1 << wb) + 14)
        end
        apb(1'b1, clock_gear_pkg::ADDR_STANDBY, 32'h1);
        mode_is(clock_gear_pkg::main_sleep);
        pulse(3, 2);
        mode_is(clock_gear_pkg::main_run);
        apb(1'b1, clock_gear_pkg::ADDR_STANDBY, 32'h2);
        mode_is(clock_gear_pkg::main_stop);
        pulse(3, 2);
        mode_is(clock_gear_pkg::main_stop);
        pulse(4, 3);
        mode_is(clock_gear_pkg::main_wait);
        hold_to(1'b0);
        mode_is(clock_gear_pkg::main_run);
        apb(1'b1, clock_gear_pkg::ADDR_STANDBY, 32'h3);
        mode_is(clock_gear_pkg::main_run);
        apb(1'b1, clock_gear_pkg::ADDR_CLK_CTRL, 32'h2);
        apb(1'b1, clock_gear_pkg::ADDR_STANDBY, 32'h1);
        mode_is(clock_gear_pkg::sub_sleep);
        pulse(3, 2);
        mode_is(clock_gear_pkg::sub_run);
        apb(1'b1, clock_gear_pkg::ADDR_STANDBY, 32'h3);
        mode_is(clock_gear_pkg::watch_mode);
        pulse(1, 1);
        hold_to(1'b1);
        hold_to(1'b0);
        ctrl_is(32'h84);
        apb(1'b1, clock_gear_pkg::ADDR_CLK_CTRL, 32'h1);
        apb(1'b1, clock_gear_pkg::ADDR_STANDBY, 32'h2);
        mode_is(clock_gear_pkg::sub_stop);
        `CHK("sub osc", 1'b0, sub_osc_en_out)
        pulse(0, 1);
        hold_to(1'b1);
        hold_to(1'b0);
        mode_is(clock_gear_pkg::main_run);
        pulse(2, 1);
        hold_to(1'b1);
        hold_to(1'b0);
        apb(1'b1, clock_gear_pkg::ADDR_CLK_CTRL, 32'h2);
        apb(1'b1, clock_gear_pkg::ADDR_STANDBY, 32'h10);
        hold_to(1'b1);
        hold_to(1'b0);
        ctrl_is(32'h84);
        conclude();
    end
endmodule
